// ### porsq_sequencer.sv
// power-on reset sequencer and power-state tracker of the memory hub
`timescale 1ns/1ns
`include "porsq_defines.svh"
module porsq_sequencer
    import porsq_pkg::*;
#(
    parameter int CPU_RST_CYCLES = `PORSQ_CPU_RST_US * `PORSQ_CLK_MHZ  // processor hold in clocks
)(
    input  wire logic          core_clk,               // host clock, 250 MHz
    input  wire logic          rst_n,                  // synchronous reset, active low
    input  wire logic          power_good_in,          // platform power good, asynchronous
    input  wire logic          system_reset_in_n,      // system reset from io hub, active low
    input  wire logic          hub_link_handshake_ack, // io hub answer to the handshake
    input  wire porsq_sstate_e sleep_state_req,        // requested system state
    input  wire logic          cpu_cstate_valid,       // processor state message present
    input  wire porsq_cstate_e cpu_cstate_req,         // requested processor state
    output logic               hard_reset_n,           // internal hard reset, active low
    output logic               core_reset_n,           // internal core reset, active low
    output logic               processor_reset_out_n,  // processor reset, active low
    output logic               hub_link_handshake_req, // device side of the handshake
    output porsq_sstate_e      power_state,            // present system and device state
    output logic               io_hub_low_power_ok,    // io hub may leave D0
    output porsq_cstate_e      cpu_cstate              // acknowledged processor state
);

    localparam logic [`PORSQ_CNT_W-1:0] CPU_CNT = `PORSQ_CNT_W'(CPU_RST_CYCLES);

    // ****************************************
    // power-good synchroniser
    // ****************************************
    logic pg_meta;  // first stage, read only by pg_sync
    logic pg_sync;  // power good in the host domain

    // power good has no tie to any clock, so it passes two flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pg_meta <= 1'b0;
            pg_sync <= 1'b0;
        end else begin
            pg_meta <= power_good_in;
            pg_sync <= pg_meta;
        end
    end

    // ****************************************
    // common clock edge
    // ****************************************
    logic [`PORSQ_EDGE_W-1:0] edge_phase;  // host clocks into the slow period

    wire logic common_edge = (edge_phase == `PORSQ_EDGE_W'(`PORSQ_EDGE_DIV - 1));  // all clocks rise next

    // free-running phase of the slowest internal clock
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            edge_phase <= '0;
        end else if (common_edge) begin
            edge_phase <= '0;
        end else begin
            edge_phase <= edge_phase + `PORSQ_EDGE_W'(1);
        end
    end

    // ****************************************
    // state machine
    // ****************************************
    porsq_state_e            state;       // present state
    porsq_state_e            next_state;  // state after this edge
    logic [`PORSQ_DLY_W-1:0] core_dly;    // clocks since system reset released

    porsq_tmr_if tmr_bus ();  // link to the millisecond timer

    wire logic rst_release = (state == PORSQ_HOLD) && system_reset_in_n;  // system reset just let go
    wire logic core_due    = (core_dly >= `PORSQ_DLY_W'(`PORSQ_CORE_DLY_MIN - 1)) && common_edge;
    wire logic sleep_deep  = (sleep_state_req == PORSQ_S4) || (sleep_state_req == PORSQ_S5);

    // next state; power good and system reset take priority everywhere
    always_comb begin
        next_state = state;
        case (state)
            PORSQ_POR: begin
                next_state = PORSQ_HOLD;  // power good present, wait for system reset
            end
            PORSQ_HOLD: begin
                if (system_reset_in_n) next_state = PORSQ_CORE_WAIT;
            end
            PORSQ_CORE_WAIT: begin
                if (core_due) next_state = PORSQ_CPU_WAIT;
            end
            PORSQ_CPU_WAIT: begin
                if (tmr_bus.expired) next_state = PORSQ_HSHAKE;
            end
            PORSQ_HSHAKE: begin
                if (hub_link_handshake_ack) next_state = PORSQ_RUN;
            end
            PORSQ_RUN: begin
                if (sleep_deep) next_state = PORSQ_OFF;
            end
            PORSQ_OFF: begin
                next_state = PORSQ_OFF;
            end
            default: begin
                next_state = PORSQ_POR;
            end
        endcase
        if (!system_reset_in_n && state != PORSQ_POR) next_state = PORSQ_HOLD;
        if (!pg_sync) next_state = PORSQ_POR;
    end

    // ****************************************
    // registered outputs, next values
    // ****************************************
    wire logic in_run      = (next_state == PORSQ_RUN);
    wire logic next_core_n = (next_state == PORSQ_CPU_WAIT) || (next_state == PORSQ_HSHAKE) || in_run;
    wire logic next_cpu_n  = in_run;  // released only once the io hub answered
    wire logic next_hs_req = (next_state == PORSQ_HSHAKE);
    wire logic next_off    = (next_state == PORSQ_OFF);
    wire logic cstate_ok   = cpu_cstate_valid && (cpu_cstate_req != PORSQ_C3 || power_state == PORSQ_S0);

    // the deep state is taken once on entry; later requests must not wake the reported state
    wire logic          enter_off   = next_off && (state != PORSQ_OFF);
    wire porsq_sstate_e next_pstate = (in_run || enter_off) ? sleep_state_req
                                                            : (next_off ? power_state : PORSQ_S0);

    // state and the core delay counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state    <= PORSQ_POR;
            core_dly <= '0;
        end else begin
            state    <= next_state;
            core_dly <= (state == PORSQ_CORE_WAIT) ? core_dly + `PORSQ_DLY_W'(1) : '0;
        end
    end

    // reset outputs; hard and core share one flop input so they move together
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hard_reset_n          <= 1'b0;
            core_reset_n          <= 1'b0;
            processor_reset_out_n <= 1'b0;
            hub_link_handshake_req <= 1'b0;
        end else begin
            hard_reset_n          <= next_core_n;
            core_reset_n          <= next_core_n;
            processor_reset_out_n <= next_cpu_n;
            hub_link_handshake_req <= next_hs_req;
        end
    end

    // power states; the device has no state of its own beyond the system one
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            power_state         <= PORSQ_S0;
            io_hub_low_power_ok <= 1'b0;
            cpu_cstate          <= PORSQ_C0;
        end else begin
            power_state         <= next_pstate;
            io_hub_low_power_ok <= next_off;
            // processors wake to C0 after any reset; the bus itself never sleeps
            if (!in_run) begin
                cpu_cstate <= PORSQ_C0;
            end else if (cstate_ok) begin
                cpu_cstate <= cpu_cstate_req;
            end
        end
    end

    // ****************************************
    // millisecond timer
    // ****************************************
    // started at release of system reset, emptied by any new reset
    assign tmr_bus.start = rst_release;
    assign tmr_bus.clear = (next_state == PORSQ_POR) || (next_state == PORSQ_HOLD);

    porsq_timer #(
        .W      (`PORSQ_CNT_W),
        .CYCLES (CPU_CNT)
    ) u_cpu_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tif      (tmr_bus)
    );

    // ****************************************
    // checks
    // ****************************************
    logic [`PORSQ_CNT_W-1:0] since_rel;  // clocks since leaving the held state

    // saturating count used only by the checks below
    always_ff @(posedge core_clk) begin
        if (!rst_n || state == PORSQ_HOLD || state == PORSQ_POR) begin
            since_rel <= '0;
        end else if (since_rel != '1) begin
            since_rel <= since_rel + `PORSQ_CNT_W'(1);
        end
    end

    property p_core_window;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(core_reset_n) |-> (since_rel >= `PORSQ_CNT_W'(`PORSQ_CORE_DLY_MIN))
                              && (since_rel <= `PORSQ_CNT_W'(`PORSQ_CORE_DLY_MAX));
    endproperty
    a_core_window: assert property (p_core_window) else $error("core release outside window");

    property p_hard_core_same;
        @(posedge core_clk) disable iff (!rst_n)
        hard_reset_n == core_reset_n;
    endproperty
    a_hard_core_same: assert property (p_hard_core_same) else $error("hard and core resets differ");

    property p_cpu_hold;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(processor_reset_out_n) |-> since_rel > CPU_CNT;
    endproperty
    a_cpu_hold: assert property (p_cpu_hold) else $error("processor reset released early");

    property p_hs_bracket;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(processor_reset_out_n) |-> $past(hub_link_handshake_req) && $past(hub_link_handshake_ack)
                                         && !hub_link_handshake_req;
    endproperty
    a_hs_bracket: assert property (p_hs_bracket) else $error("processor release without handshake");

    property p_off_sticky;
        @(posedge core_clk) disable iff (!rst_n)
        (state == PORSQ_OFF) && pg_sync && system_reset_in_n |=> (state == PORSQ_OFF) && !processor_reset_out_n;
    endproperty
    a_off_sticky: assert property (p_off_sticky) else $error("left deep sleep without reset");

    property p_io_d0;
        @(posedge core_clk) disable iff (!rst_n)
        io_hub_low_power_ok |-> (power_state == PORSQ_S4) || (power_state == PORSQ_S5);
    endproperty
    a_io_d0: assert property (p_io_d0) else $error("io hub released from D0 while awake");

    property p_cstate;
        @(posedge core_clk) disable iff (!rst_n)
        (state == PORSQ_RUN) && in_run && cstate_ok |=> cpu_cstate == $past(cpu_cstate_req);
    endproperty
    a_cstate: assert property (p_cstate) else $error("processor state not taken");

    property p_por_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !pg_sync |=> !core_reset_n && !processor_reset_out_n ##1 !hard_reset_n;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("resets released without power good");

    property p_hard_reset;
        @(posedge core_clk) disable iff (!rst_n)
        pg_sync && !system_reset_in_n |=> !processor_reset_out_n && !core_reset_n;
    endproperty
    a_hard_reset: assert property (p_hard_reset) else $error("hard reset did not hold processors");

endmodule

// ### porsq_defines.svh
// constants for the power-on reset sequencer
`ifndef PORSQ_DEFINES_SVH
`define PORSQ_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define PORSQ_CLK_MHZ       250       // host clock rate in MHz
`define PORSQ_CPU_RST_US    1000      // processor reset hold, 1 ms in us
`define PORSQ_CORE_DLY_MIN  4         // least host clocks before core release
`define PORSQ_CORE_DLY_MAX  6         // most host clocks before core release
`define PORSQ_EDGE_DIV      2         // ratio of slowest internal clock to host clock
`define PORSQ_EDGE_W        1         // width of the common-edge phase counter
`define PORSQ_DLY_W         3         // width of the core delay counter
`define PORSQ_CNT_W         20        // width of the millisecond timer

`endif

// ### porsq_pkg.sv
// types shared by the power-on reset sequencer files
package porsq_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        PORSQ_POR,        // power-good low, everything held
        PORSQ_HOLD,       // system reset input asserted
        PORSQ_CORE_WAIT,  // counting to the common clock edge
        PORSQ_CPU_WAIT,   // millisecond timer running
        PORSQ_HSHAKE,     // hub handshake around processor release
        PORSQ_RUN,        // S0 or S1
        PORSQ_OFF         // S4 or S5, waits for full reset
    } porsq_state_e;

    // supported system sleep states
    typedef enum logic [1:0] {
        PORSQ_S0,
        PORSQ_S1,
        PORSQ_S4,
        PORSQ_S5
    } porsq_sstate_e;

    // supported processor power states
    typedef enum logic [1:0] {
        PORSQ_C0,
        PORSQ_C1,
        PORSQ_C3
    } porsq_cstate_e;

endpackage

// ### porsq_tmr_if.sv
// control lines between the sequencer and its millisecond timer
`timescale 1ns/1ns
interface porsq_tmr_if;
    logic start;    // one-cycle pulse, restarts the count
    logic clear;    // level, stops and empties the timer
    logic expired;  // level, full time has elapsed

    modport ctrl (output start, output clear, input expired);
    modport tmr  (input start, input clear, output expired);
endinterface

// ### porsq_timer.sv
// host-clock counter that measures one fixed delay
`timescale 1ns/1ns
`include "porsq_defines.svh"
module porsq_timer
    import porsq_pkg::*;
#(
    parameter int                  W      = `PORSQ_CNT_W,  // counter width
    parameter logic [W-1:0]        CYCLES = W'(`PORSQ_CPU_RST_US * `PORSQ_CLK_MHZ)  // cycles to measure
)(
    input  wire logic core_clk,  // host clock
    input  wire logic rst_n,     // synchronous reset, active low
    porsq_tmr_if.tmr  tif        // start, clear and expiry
);

    logic [W-1:0] remain;   // cycles still to run
    logic         running;  // a count is in progress or finished

    wire logic at_zero = (remain == '0);  // nothing left to count

    // ****************************************
    // counter
    // ****************************************
    // load on start, count down to zero, hold there until cleared
    always_ff @(posedge core_clk) begin
        if (!rst_n || tif.clear) begin
            remain  <= '0;
            running <= 1'b0;
        end else if (tif.start) begin
            remain  <= CYCLES - W'(1);
            running <= 1'b1;
        end else if (!at_zero) begin
            remain  <= remain - W'(1);
        end
    end

    assign tif.expired = running && at_zero;

endmodule

// ### porsq_hub_model.sv
// behavioural io hub: drives system reset and answers the handshake
`timescale 1ns/1ns
module porsq_hub_model #(
    parameter int HOLD = 30  // reset hold after power good, scaled from 1 ms
)(
    input  wire logic       core_clk,               // host clock
    input  wire logic       power_good_in,          // platform power good
    input  wire logic       force_rst,              // bench command for a hard reset
    input  wire logic [7:0] ack_dly,                // clocks before the answer
    input  wire logic       hub_link_handshake_req, // device request
    output logic            system_reset_in_n,      // reset into the device, active low
    output logic            hub_link_handshake_ack  // answer to the device
);
    int hcnt;  // reset hold counter
    int acnt;  // answer delay counter

    // ****************************************
    // reset output and handshake answer
    // ****************************************
    // reset follows power good, then a fixed hold before release
    // outputs settle on the first edges, while the bench still holds the device in reset
    always @(posedge core_clk) begin
        if (!power_good_in || force_rst) begin
            hcnt <= 0;
            system_reset_in_n <= 1'b0;
        end else if (hcnt < HOLD) begin
            hcnt <= hcnt + 1;
        end else begin
            system_reset_in_n <= 1'b1;
        end
    end

    // answer only after the chosen delay, drop once the request goes
    always @(posedge core_clk) begin
        if (!hub_link_handshake_req) begin
            acnt <= 0;
            hub_link_handshake_ack <= 1'b0;
        end else if (acnt < ack_dly) begin
            acnt <= acnt + 1;
        end else begin
            hub_link_handshake_ack <= 1'b1;
        end
    end
endmodule

// ### tb_top.sv
// self-checking bench for the power-on reset sequencer
`timescale 1ns/1ns
module tb_top
    import porsq_pkg::*;
;
    localparam int CPU_N = 20;    // short processor hold for simulation
    localparam int LIMIT = 6000;  // cycle ceiling for the whole run

    logic          core_clk;      // host clock
    logic          rst_n;         // bench reset
    logic          power_good_in; // platform power good
    logic          force_rst;     // hard reset command to the hub model
    logic [7:0]    ack_dly;       // hub answer delay
    porsq_sstate_e sleep_state_req;
    logic          cpu_cstate_valid;
    porsq_cstate_e cpu_cstate_req;
    logic          system_reset_in_n, hub_link_handshake_ack;
    logic          hard_reset_n, core_reset_n, processor_reset_out_n;
    logic          hub_link_handshake_req, io_hub_low_power_ok;
    porsq_sstate_e power_state;
    porsq_cstate_e cpu_cstate;
    int            err_count = 0;  // mismatches
    int            tests_run = 0;  // comparisons
    int            cyc = 0;        // cycle counter for the ceiling

    porsq_sequencer #(.CPU_RST_CYCLES(CPU_N)) u_porsq_sequencer (
        .core_clk(core_clk), .rst_n(rst_n), .power_good_in(power_good_in),
        .system_reset_in_n(system_reset_in_n), .hub_link_handshake_ack(hub_link_handshake_ack),
        .sleep_state_req(sleep_state_req), .cpu_cstate_valid(cpu_cstate_valid),
        .cpu_cstate_req(cpu_cstate_req), .hard_reset_n(hard_reset_n), .core_reset_n(core_reset_n),
        .processor_reset_out_n(processor_reset_out_n), .hub_link_handshake_req(hub_link_handshake_req),
        .power_state(power_state), .io_hub_low_power_ok(io_hub_low_power_ok), .cpu_cstate(cpu_cstate));

    porsq_hub_model u_porsq_hub_model (
        .core_clk(core_clk), .power_good_in(power_good_in), .force_rst(force_rst), .ack_dly(ack_dly),
        .hub_link_handshake_req(hub_link_handshake_req), .system_reset_in_n(system_reset_in_n),
        .hub_link_handshake_ack(hub_link_handshake_ack));

    // ****************************************
    // clock, ceiling and reporting
    // ****************************************
    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    // a hang is cut short and counted as a mismatch
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
            err_count++;
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // follows one release: core timing, handshake and processor release
    task automatic boot_chk(input int d);
        int k, hk, pk, ak;
        bit seen, split;
        hk = 0; pk = 0; ak = 0; seen = 0; split = 0;
        for (k = 0; k < 300 && system_reset_in_n !== 1'b1; k++) begin
            @(posedge core_clk); #1;
        end
        for (k = 1; k < 300 && pk == 0; k++) begin
            @(posedge core_clk); #1;
            split |= (hard_reset_n !== core_reset_n);
            if (hk == 0 && hard_reset_n === 1'b1) hk = k;
            if (ak == 0 && hub_link_handshake_ack === 1'b1) ak = k;
            if (hub_link_handshake_req === 1'b1) seen = 1;
            if (processor_reset_out_n === 1'b1) pk = k;
        end
        chk("hard_core_equal", 0, split);
        chk("core_release_ok", 1, hk >= 4 && hk <= 6);
        chk("req_seen", 1, seen);
        chk("ack_before_cpu", 1, ak > 0 && pk > ak);
        chk("cpu_release_ok", 1, pk >= CPU_N + d && pk <= CPU_N + d + 4);
        chk("req_dropped", 0, hub_link_handshake_req);
        chk("run_state", PORSQ_S0, power_state);
    endtask

    // one processor state message and the accepted result
    task automatic cstate(input porsq_cstate_e c, input porsq_cstate_e e);
        @(posedge core_clk);
        cpu_cstate_valid <= 1'b1;
        cpu_cstate_req <= c;
        @(posedge core_clk);
        cpu_cstate_valid <= 1'b0;
        @(posedge core_clk); #1;
        chk("cpu_cstate", e, cpu_cstate);
    endtask

    task automatic t_sleep;
        @(posedge core_clk);
        sleep_state_req <= PORSQ_S1;
        repeat (2) @(posedge core_clk); #1;
        chk("s1_state", PORSQ_S1, power_state);
        chk("s1_resets", 3'h7, {hard_reset_n, core_reset_n, processor_reset_out_n});
        chk("s1_lp", 0, io_hub_low_power_ok);
        cstate(PORSQ_C1, PORSQ_C1);
        cstate(PORSQ_C3, PORSQ_C1);
        @(posedge core_clk);
        sleep_state_req <= PORSQ_S0;
        cstate(PORSQ_C3, PORSQ_C3);
        cstate(PORSQ_C0, PORSQ_C0);
        cstate(PORSQ_C1, PORSQ_C1);
    endtask

    // hard reset from the hub, with a chosen answer delay afterwards
    task automatic t_hard(input int d);
        @(posedge core_clk);
        force_rst <= 1'b1;
        repeat (3) @(posedge core_clk); #1;
        chk("hard_resets", 0, {hard_reset_n, core_reset_n, processor_reset_out_n});
        chk("hard_req", 0, hub_link_handshake_req);
        @(posedge core_clk);
        force_rst <= 1'b0;
        ack_dly <= 8'(d);
        boot_chk(d);
    endtask

    // deep sleep is left only through a full reset
    task automatic t_off(input porsq_sstate_e s);
        @(posedge core_clk);
        sleep_state_req <= s;
        repeat (3) @(posedge core_clk); #1;
        chk("off_state", s, power_state);
        chk("off_resets", 0, {hard_reset_n, core_reset_n, processor_reset_out_n});
        chk("off_lp", 1, io_hub_low_power_ok);
        chk("off_cstate", PORSQ_C0, cpu_cstate);
        @(posedge core_clk);
        sleep_state_req <= PORSQ_S0;
        repeat (4) @(posedge core_clk); #1;
        chk("off_stays", 1, io_hub_low_power_ok);
        chk("off_held", 0, hard_reset_n);
        chk("off_pstate", s, power_state);
        t_hard(1);
    endtask

    task automatic t_pwr_fail;
        @(posedge core_clk);
        power_good_in <= 1'b0;
        repeat (4) @(posedge core_clk); #1;
        chk("pf_resets", 0, {hard_reset_n, core_reset_n, processor_reset_out_n});
        chk("pf_lp", 0, io_hub_low_power_ok);
        @(posedge core_clk);
        power_good_in <= 1'b1;
        ack_dly <= 8'h02;
        boot_chk(2);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        power_good_in = 1'b0;
        force_rst = 1'b0;
        ack_dly = 8'h02;
        sleep_state_req = PORSQ_S0;
        cpu_cstate_valid = 1'b0;
        cpu_cstate_req = PORSQ_C0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        power_good_in <= 1'b1;
        boot_chk(2);
        t_sleep();
        t_hard(25);
        t_off(PORSQ_S4);
        t_off(PORSQ_S5);
        t_pwr_fail();
        summarize();
    end
endmodule
